// ### pkg/sfc_pkg.sv
// Purpose: shared constants for the serial flash command front end
// Assumes: 200 MHz system clock, serial clock sampled as a plain input
// Notes: status layout and opcode values
package sfc_pkg;
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_CLR_LATCH = 8'h04;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_WR = 8'h01;
   localparam logic [7:0] OP_PROGRAM = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_SECT_ERASE_A = 8'h20;
   localparam logic [7:0] OP_SECT_ERASE_B = 8'hD7;
   localparam logic [7:0] OP_BLK_ERASE_A = 8'h52;
   localparam logic [7:0] OP_BLK_ERASE_B = 8'hD8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
   localparam logic [7:0] OP_ID_A = 8'h9F;
   localparam logic [7:0] OP_ID_B = 8'hAB;
   localparam logic [7:0] OP_DONT_CARE_MASK = 8'hF7;
   localparam int BIT_BUSY = 0;
   localparam int BIT_WEL = 1;
   localparam int BIT_PPE = 7;
   localparam logic [7:0] STAT_WR_MASK = 8'hEC;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] STAT_BUSY_READ = 8'hFF;
   localparam int WRITE_CYCLES = 64;
   typedef enum logic [2:0] {
      SFC_IDLE, SFC_OPCODE, SFC_STAT_DATA, SFC_STAT_OUT, SFC_SINK, SFC_DEAD
   } sfc_state_type;
endpackage

// ### src/sfc_front_end.sv
// Purpose: slave-side command front end of a small serial flash
// Assumes: sck, cs_n, si, hold_n, write_protect_n come from pins, synchronised here
// Notes: array data phases are not modelled; array opcodes decode into events only
`timescale 1ns/100ps
`default_nettype none
module sfc_front_end #(
   parameter int WRITE_CYCLES = sfc_pkg::WRITE_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic write_protect_n,
   output logic so,
   output logic so_oe,
   output logic [7:0] status_q,
   output logic [2:0] locked_level_q,
   output logic hw_protect_q,
   output logic [7:0] opcode_q,
   output logic program_cmd_q,
   output logic erase_cmd_q,
   output logic read_cmd_q,
   output logic id_cmd_q
);
   logic [1:0] sck_s, cs_s, si_s, hold_s, wp_s;
   logic sck_q, cs_q;
   sfc_pkg::sfc_state_type state_q;
   logic [7:0] shift_q, out_q, stat_q, new_stat_q;
   logic [2:0] bit_q;
   logic wel_q, busy_q, pend_q, so_q;
   logic [15:0] wcnt_q;
   logic rise, fall, sel_start, sel_end, paused, byte_done, hw_prot;
   logic [7:0] nb, masked;

   // every pin passes two flops; sck and cs_n also pass a third, read with the second stage to find edges
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sck_s <= 2'b00;
         cs_s <= 2'b11;
         si_s <= 2'b00;
         hold_s <= 2'b11;
         wp_s <= 2'b11;
         sck_q <= 1'b0;
         cs_q <= 1'b1;
      end else begin
         sck_s <= {sck_s[0], sck};
         cs_s <= {cs_s[0], cs_n};
         si_s <= {si_s[0], si};
         hold_s <= {hold_s[0], hold_n};
         wp_s <= {wp_s[0], write_protect_n};
         sck_q <= sck_s[1];
         cs_q <= cs_s[1];
      end
   end

   assign rise = sck_s[1] & ~sck_q;
   assign fall = ~sck_s[1] & sck_q;
   assign sel_start = ~cs_s[1] & cs_q;
   assign sel_end = cs_s[1] & ~cs_q;
   // pause only acts when the master changes it with sck low, so no edge filter here
   assign paused = ~hold_s[1];
   assign hw_prot = ~wp_s[1] & stat_q[sfc_pkg::BIT_PPE];
   assign nb = {shift_q[6:0], si_s[1]};
   assign byte_done = rise & ~cs_s[1] & ~paused & (bit_q == 3'd7);
   assign masked = nb & sfc_pkg::OP_DONT_CARE_MASK;

   // serial sequence; reset keeps it idle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= sfc_pkg::SFC_IDLE;
         shift_q <= 8'h00;
         bit_q <= 3'd0;
         opcode_q <= 8'h00;
      end else if (cs_s[1]) begin
         state_q <= sfc_pkg::SFC_IDLE;
         bit_q <= 3'd0;
      end else begin
         if (sel_start) begin
            state_q <= sfc_pkg::SFC_OPCODE;
            bit_q <= 3'd0;
         end else if (rise && !paused && state_q != sfc_pkg::SFC_DEAD) begin
            shift_q <= nb;
            bit_q <= bit_q + 3'd1;
         end
         if (byte_done) begin
            unique case (state_q)
               sfc_pkg::SFC_OPCODE: begin
                  opcode_q <= nb;
                  if (busy_q && masked != sfc_pkg::OP_STAT_RD)
                     state_q <= sfc_pkg::SFC_SINK;
                  else if (masked == sfc_pkg::OP_STAT_RD)
                     state_q <= sfc_pkg::SFC_STAT_OUT;
                  else if (masked == sfc_pkg::OP_STAT_WR)
                     state_q <= sfc_pkg::SFC_STAT_DATA;
                  else if (masked == sfc_pkg::OP_SET_LATCH || masked == sfc_pkg::OP_CLR_LATCH
                        || masked == sfc_pkg::OP_PROGRAM || nb == sfc_pkg::OP_READ
                        || nb == sfc_pkg::OP_FAST_READ || nb == sfc_pkg::OP_SECT_ERASE_A
                        || nb == sfc_pkg::OP_SECT_ERASE_B || nb == sfc_pkg::OP_BLK_ERASE_A
                        || nb == sfc_pkg::OP_BLK_ERASE_B || nb == sfc_pkg::OP_CHIP_ERASE_A
                        || nb == sfc_pkg::OP_CHIP_ERASE_B || nb == sfc_pkg::OP_ID_A
                        || nb == sfc_pkg::OP_ID_B)
                     state_q <= sfc_pkg::SFC_SINK;
                  else
                     state_q <= sfc_pkg::SFC_DEAD;
               end
               sfc_pkg::SFC_STAT_DATA: state_q <= sfc_pkg::SFC_SINK;
               sfc_pkg::SFC_STAT_OUT, sfc_pkg::SFC_SINK, sfc_pkg::SFC_DEAD,
               sfc_pkg::SFC_IDLE: begin
               end
            endcase
         end
      end
   end

   // one-cycle decode events for the array side, which is outside this block
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         program_cmd_q <= 1'b0;
         erase_cmd_q <= 1'b0;
         read_cmd_q <= 1'b0;
         id_cmd_q <= 1'b0;
      end else begin
         program_cmd_q <= byte_done && state_q == sfc_pkg::SFC_OPCODE && !busy_q && wel_q
            && masked == sfc_pkg::OP_PROGRAM;
         erase_cmd_q <= byte_done && state_q == sfc_pkg::SFC_OPCODE && !busy_q && wel_q
            && (nb == sfc_pkg::OP_SECT_ERASE_A || nb == sfc_pkg::OP_SECT_ERASE_B
            || nb == sfc_pkg::OP_BLK_ERASE_A || nb == sfc_pkg::OP_BLK_ERASE_B
            || nb == sfc_pkg::OP_CHIP_ERASE_A || nb == sfc_pkg::OP_CHIP_ERASE_B);
         read_cmd_q <= byte_done && state_q == sfc_pkg::SFC_OPCODE && !busy_q
            && (nb == sfc_pkg::OP_READ || nb == sfc_pkg::OP_FAST_READ);
         id_cmd_q <= byte_done && state_q == sfc_pkg::SFC_OPCODE && !busy_q
            && (nb == sfc_pkg::OP_ID_A || nb == sfc_pkg::OP_ID_B);
      end
   end

   // latch, pending status write and the self-timed cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wel_q <= 1'b0;
         pend_q <= 1'b0;
         busy_q <= 1'b0;
         wcnt_q <= 16'h0000;
         new_stat_q <= 8'h00;
         stat_q <= sfc_pkg::STAT_RESET;
      end else begin
         if (byte_done && state_q == sfc_pkg::SFC_OPCODE && !busy_q) begin
            if (masked == sfc_pkg::OP_SET_LATCH)
               wel_q <= 1'b1;
            if (masked == sfc_pkg::OP_CLR_LATCH)
               wel_q <= 1'b0;
         end
         if (byte_done && state_q == sfc_pkg::SFC_STAT_DATA && wel_q && !hw_prot) begin
            pend_q <= 1'b1;
            new_stat_q <= nb;
         end
         if (pend_q && !cs_s[1] && hw_prot)
            pend_q <= 1'b0;
         if (sel_end && pend_q && !hw_prot) begin
            pend_q <= 1'b0;
            busy_q <= 1'b1;
            wcnt_q <= 16'(WRITE_CYCLES - 1);
         end else if (sel_end) begin
            pend_q <= 1'b0;
         end
         // once running, the pin no longer matters
         if (busy_q) begin
            if (wcnt_q == 16'h0000) begin
               busy_q <= 1'b0;
               wel_q <= 1'b0;
               stat_q <= (stat_q & ~sfc_pkg::STAT_WR_MASK)
                  | (new_stat_q & sfc_pkg::STAT_WR_MASK);
            end else begin
               wcnt_q <= wcnt_q - 16'h0001;
            end
         end
      end
   end

   // status view; bit 4 reads zero except while busy, when every bit reads one
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_q <= sfc_pkg::STAT_RESET;
         locked_level_q <= 3'd0;
         hw_protect_q <= 1'b0;
      end else begin
         status_q <= busy_q ? sfc_pkg::STAT_BUSY_READ
            : {stat_q[7:2], wel_q, 1'b0};
         hw_protect_q <= hw_prot;
         if (stat_q[3:2] != 2'b00)
            locked_level_q <= 3'd3 + {1'b0, stat_q[3:2]};
         else
            locked_level_q <= {1'b0, stat_q[6:5]};
      end
   end

   // status shifts out msb first on falling sck
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_q <= 8'h00;
         so_q <= 1'b0;
      end else if (byte_done && state_q == sfc_pkg::SFC_OPCODE
            && masked == sfc_pkg::OP_STAT_RD) begin
         out_q <= busy_q ? sfc_pkg::STAT_BUSY_READ : {stat_q[7:2], wel_q, 1'b0};
      end else if (fall && !paused && state_q == sfc_pkg::SFC_STAT_OUT) begin
         so_q <= out_q[7];
         out_q <= {out_q[6:0], out_q[7]};
      end
   end

   assign so = so_q;
   assign so_oe = ~cs_s[1] & ~paused & (state_q == sfc_pkg::SFC_STAT_OUT);

   dead_float_a: assert property (@(posedge clk) disable iff (!reset_n)
      state_q == sfc_pkg::SFC_DEAD |-> !so_oe) else $error("output driven after bad opcode");
   desel_float_a: assert property (@(posedge clk) disable iff (!reset_n)
      cs_s[1] |-> !so_oe) else $error("output driven while deselected");
   pause_float_a: assert property (@(posedge clk) disable iff (!reset_n)
      paused |-> !so_oe ##0 $stable(bit_q)) else $error("pause not honoured");
   prot_refuse_a: assert property (@(posedge clk) disable iff (!reset_n)
      hw_prot |=> !$rose(pend_q)) else $error("protected status write accepted");
   wp_abort_a: assert property (@(posedge clk) disable iff (!reset_n)
      pend_q && !cs_s[1] && hw_prot |=> !pend_q) else $error("pending write not aborted");
   busy_read_a: assert property (@(posedge clk) disable iff (!reset_n)
      busy_q |=> status_q == 8'hFF) else $error("busy status not all ones");
   latch_done_a: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(busy_q) |-> !wel_q) else $error("latch kept after write cycle");
   no_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
      !wel_q && !busy_q |=> !busy_q) else $error("write cycle without latch");
   busy_ignore_a: assert property (@(posedge clk) disable iff (!reset_n)
      busy_q |=> $stable(wel_q) || !busy_q) else $error("command taken while busy");

   // decode checks watch the opcode byte as it completes
   wel_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      byte_done && state_q == sfc_pkg::SFC_OPCODE && !busy_q
      && masked == sfc_pkg::OP_SET_LATCH |=> wel_q)
      else $error("set-latch opcode not taken");

   wel_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      byte_done && state_q == sfc_pkg::SFC_OPCODE && !busy_q
      && masked == sfc_pkg::OP_CLR_LATCH |=> !wel_q)
      else $error("clear-latch opcode not taken");

   stat_read_a: assert property (@(posedge clk) disable iff (!reset_n)
      byte_done && state_q == sfc_pkg::SFC_OPCODE
      && masked == sfc_pkg::OP_STAT_RD |=> state_q == sfc_pkg::SFC_STAT_OUT)
      else $error("status read not entered");

   busy_sink_a: assert property (@(posedge clk) disable iff (!reset_n)
      byte_done && state_q == sfc_pkg::SFC_OPCODE && busy_q
      && masked != sfc_pkg::OP_STAT_RD |=> state_q == sfc_pkg::SFC_SINK)
      else $error("busy command not sunk");

   dead_stay_a: assert property (@(posedge clk) disable iff (!reset_n)
      state_q == sfc_pkg::SFC_DEAD && !cs_s[1] && !sel_start
      |=> state_q == sfc_pkg::SFC_DEAD)
      else $error("left dead state while selected");

   sel_open_a: assert property (@(posedge clk) disable iff (!reset_n)
      sel_start
      |=> state_q == sfc_pkg::SFC_OPCODE && bit_q == 3'd0)
      else $error("select did not restart opcode");

   idle_desel_a: assert property (@(posedge clk) disable iff (!reset_n)
      cs_s[1]
      |=> state_q == sfc_pkg::SFC_IDLE)
      else $error("sequence kept while deselected");

   pgm_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
      program_cmd_q
      |-> $past(wel_q) && !$past(busy_q))
      else $error("program taken without latch");

   erase_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
      erase_cmd_q
      |-> $past(wel_q) && !$past(busy_q))
      else $error("erase taken without latch");

   busy_start_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(busy_q)
      |-> $past(pend_q) && $past(sel_end))
      else $error("write cycle started off deselect");

   stat_commit_a: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(busy_q) |-> (stat_q & sfc_pkg::STAT_WR_MASK)
      == (new_stat_q & sfc_pkg::STAT_WR_MASK))
      else $error("status bits not committed");

   stat_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      !busy_q
      |=> status_q[sfc_pkg::BIT_BUSY] == 1'b0 && status_q[4] == 1'b0)
      else $error("ready or unused bit wrong");

   wel_view_a: assert property (@(posedge clk) disable iff (!reset_n)
      !busy_q
      |=> status_q[sfc_pkg::BIT_WEL] == $past(wel_q))
      else $error("latch bit not shown");

   hw_view_a: assert property (@(posedge clk) disable iff (!reset_n)
      1'b1
      |=> hw_protect_q == $past(hw_prot))
      else $error("protect view lags");

   level_top_a: assert property (@(posedge clk) disable iff (!reset_n)
      stat_q[3:2] != 2'b00
      |=> locked_level_q >= 3'd4)
      else $error("upper level bits not preferred");

   pin_ignored_a: assert property (@(posedge clk) disable iff (!reset_n)
      !stat_q[sfc_pkg::BIT_PPE]
      |-> !hw_prot)
      else $error("pin acts with enable clear");

   pause_shift_a: assert property (@(posedge clk) disable iff (!reset_n)
      paused
      |=> $stable(shift_q))
      else $error("input shifted during pause");

   pause_out_a: assert property (@(posedge clk) disable iff (!reset_n)
      paused
      |=> $stable(so_q))
      else $error("output shifted during pause");
endmodule
`default_nettype wire

// ### dv/sfc_spi_master.sv
// Purpose: spi master model for the flash front end pins
// Assumes: mode 0, sck period 80 ns, tasks called from the bench
// Notes: sck stands still low outside frames
`timescale 1ns/100ps
`default_nettype none
module sfc_spi_master (
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   task automatic sel();
      cs_n = 1'b0;
      #40;
   endtask
   // opcode first, every byte msb first
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si = tx[i];
         #40 sck = 1'b1;
         rx[i] = so;
         #40 sck = 1'b0;
      end
   endtask
   // released line flips so a stale bit never passes as data
   task automatic desel();
      #40 cs_n = 1'b1;
      si = ~si;
      #100;
   endtask
endmodule
`default_nettype wire

// ### dv/serial_flash_command_front_end_tb_top.sv
// Purpose: self-checking bench for the serial flash command front end
// Assumes: master model drives sck, cs_n, si; bench drives hold and protect
// Notes: write time raised from 64 to 600 clocks so a busy read fits in the cycle
`timescale 1ns/100ps
`default_nettype none
module serial_flash_command_front_end_tb_top;
   localparam int WC = 600;
   logic clk = 1'b0, reset_n = 1'b0, hold_n = 1'b1, wp_n = 1'b1;
   logic sck, cs_n, si, so, so_oe, hwp, pgm, ers, rd, idc;
   logic [7:0] status_q, rx, d, ev_exp, opc;
   logic [2:0] lvl;
   logic [3:0] evq[$];
   logic [11:0] ops[12] = '{12'h032, 12'h0B2, 12'h9F1, 12'hAB1, 12'h204, 12'hD74,
      12'h524, 12'hD84, 12'h604, 12'hC74, 12'h028, 12'h0A8};
   logic [7:0] lat[4] = '{8'h06, 8'h0C, 8'h0E, 8'h04};
   int n_fail = 0, num_checks = 0, cyc = 0;
   integer seed = 32'h9893_1a66;
   always #2.5 clk = ~clk;
   // a floating output shows the inverse so a stale bit never reads as data
   sfc_spi_master u_mst (.sck(sck), .cs_n(cs_n), .si(si), .so(so_oe ? so : ~so));
   sfc_front_end #(.WRITE_CYCLES(WC)) u_dut (.clk(clk), .reset_n(reset_n), .sck(sck),
      .cs_n(cs_n), .si(si), .hold_n(hold_n), .write_protect_n(wp_n), .so(so), .so_oe(so_oe),
      .status_q(status_q), .locked_level_q(lvl), .hw_protect_q(hwp), .opcode_q(opc),
      .program_cmd_q(pgm), .erase_cmd_q(ers), .read_cmd_q(rd), .id_cmd_q(idc));
   task automatic wrap_up();
      $display("checks=%0d fails=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input bit nd);
      @(negedge clk);
      u_mst.sel();
      u_mst.xfer(op, rx);
      if (nd) u_mst.xfer(dat, rx);
      u_mst.desel();
   endtask
   // set latch, then status write, then sit out the write time
   task automatic wr(input logic [7:0] dat);
      cmd(sfc_pkg::OP_SET_LATCH, 8'h00, 1'b0);
      cmd(sfc_pkg::OP_STAT_WR, dat, 1'b1);
      #(WC * 5 + 500);
   endtask
   // an event with no note pending means an opcode was wrongly taken
   always @(negedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         wrap_up();
      end
      if ((pgm | ers | rd | idc) === 1'b1) begin
         ev_exp = (evq.size() != 0) ? {4'h0, evq.pop_front()} : 8'hFF;
         chk({4'h0, pgm, ers, rd, idc}, ev_exp);
      end
   end
   initial begin
      repeat (16) @(negedge clk);
      chk({7'h0, so_oe}, 8'h00);
      chk(status_q, 8'h00);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      cmd(8'h0D, 8'h00, 1'b1);
      chk(rx, 8'h00);
      foreach (lat[i]) begin
         cmd(lat[i], 8'h00, 1'b0);
         cmd(sfc_pkg::OP_STAT_RD, 8'h00, 1'b1);
         chk(rx, {6'h0, lat[i][1], 1'b0});
      end
      foreach (ops[i]) begin
         if (ops[i][3:2] != 2'b00) cmd(sfc_pkg::OP_SET_LATCH, 8'h00, 1'b0);
         evq.push_back(ops[i][3:0]);
         cmd(ops[i][11:4], 8'h00, 1'b0);
         #(WC * 5 + 500);
      end
      cmd(sfc_pkg::OP_CLR_LATCH, 8'h00, 1'b0);
      @(negedge clk);
      u_mst.sel();
      u_mst.xfer(8'h13, rx);
      u_mst.xfer(sfc_pkg::OP_STAT_RD, rx);
      u_mst.xfer(8'h00, rx);
      chk({7'h0, so_oe}, 8'h00);
      u_mst.desel();
      cmd(sfc_pkg::OP_STAT_WR, 8'($random(seed)), 1'b1);
      #(WC * 5 + 500);
      cmd(sfc_pkg::OP_STAT_RD, 8'h00, 1'b1);
      chk(rx, 8'h00);
      cmd(sfc_pkg::OP_SET_LATCH, 8'h00, 1'b0);
      cmd(sfc_pkg::OP_STAT_WR, 8'hFF, 1'b1);
      cmd(sfc_pkg::OP_ID_A, 8'h00, 1'b0);
      cmd(sfc_pkg::OP_STAT_RD, 8'h00, 1'b1);
      chk(rx, 8'hFF);
      #(WC * 5);
      cmd(sfc_pkg::OP_STAT_RD, 8'h00, 1'b1);
      chk(rx, 8'hEC);
      chk({5'h0, lvl}, 8'h06);
      chk({7'h0, hwp}, 8'h00);
      wp_n = 1'b0;
      repeat (8) @(negedge clk);
      chk({7'h0, hwp}, 8'h01);
      wr(8'h00);
      cmd(sfc_pkg::OP_STAT_RD, 8'h00, 1'b1);
      chk(rx, 8'hEE);
      wp_n = 1'b1;
      cmd(sfc_pkg::OP_STAT_WR, 8'h80, 1'b1);
      #(WC * 5 + 500);
      cmd(sfc_pkg::OP_SET_LATCH, 8'h00, 1'b0);
      @(negedge clk);
      u_mst.sel();
      u_mst.xfer(sfc_pkg::OP_STAT_WR, rx);
      u_mst.xfer(8'h84, rx);
      wp_n = 1'b0;
      u_mst.desel();
      cmd(sfc_pkg::OP_STAT_RD, 8'h00, 1'b1);
      chk(rx, 8'h82);
      wp_n = 1'b1;
      cmd(sfc_pkg::OP_STAT_WR, 8'h84, 1'b1);
      wp_n = 1'b0;
      #(WC * 5 + 500);
      cmd(sfc_pkg::OP_STAT_RD, 8'h00, 1'b1);
      chk(rx, 8'h84);
      wp_n = 1'b1;
      d = 8'($random(seed)) & 8'h7F;
      wr(d);
      cmd(sfc_pkg::OP_STAT_RD, 8'h00, 1'b1);
      chk(rx, d & sfc_pkg::STAT_WR_MASK);
      wp_n = 1'b0;
      wr(8'h24);
      cmd(sfc_pkg::OP_STAT_RD, 8'h00, 1'b1);
      chk(rx, 8'h24);
      chk({5'h0, lvl}, 8'h04);
      @(negedge clk);
      u_mst.sel();
      u_mst.xfer(sfc_pkg::OP_STAT_RD, rx);
      // let the last sck fall be seen before pausing, with sck low
      repeat (4) @(negedge clk);
      hold_n = 1'b0;
      repeat (8) @(negedge clk);
      chk({7'h0, so_oe}, 8'h00);
      hold_n = 1'b1;
      repeat (8) @(negedge clk);
      u_mst.xfer(8'h00, rx);
      u_mst.desel();
      chk(rx, 8'h24);
      chk(8'(evq.size()), 8'h00);
      chk(opc, sfc_pkg::OP_STAT_RD);
      wrap_up();
   end
endmodule
`default_nettype wire
